// *** rhps_port_ctrl.sv ***
`timescale 1ns/1ps
module rhps_port_ctrl #(
    parameter int unsigned RESET_CYCLES  = rhps_pkg::RHPS_RESET_CYCLES,
    parameter int unsigned RESUME_CYCLES = rhps_pkg::RHPS_RESUME_CYCLES
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_b_i,
    input  wire rhps_pkg::rhps_reg_req_t reg_req_i,
    input  wire rhps_pkg::rhps_port_in_t port_in_i,
    output logic [31:0]                  reg_rdata_o,
    output logic                         reg_rvalid_o,
    output logic                         port_reset_drive_o,
    output logic                         port_resume_drive_o,
    output logic                         port_suspend_o,
    output logic                         port_enabled_o,
    output logic                         hc_resume_req_o
);
    import rhps_pkg::*;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == RHPS_PORT_STATUS_OFS);
    endfunction

    rhps_state_t                st_reg;
    rhps_state_t                st_next;
    logic [RHPS_CNT_W-1:0]      cnt_reg;
    logic [RHPS_CNT_W-1:0]      cnt_next;
    logic                       pes_reg;
    logic                       pes_next;
    logic [RHPS_CHG_W-1:0]      chg_reg;
    logic [RHPS_CHG_W-1:0]      chg_next;
    logic [RHPS_CHG_W-1:0]      chg_set;
    logic [RHPS_CHG_W-1:0]      chg_clr;
    logic                       conn_d_reg;
    logic                       oc_d_reg;
    logic                       hc_req_reg;
    logic                       hc_req_next;
    logic [31:0]                rdata_reg;
    logic [31:0]                rdata_next;
    logic                       rvalid_reg;
    logic                       rvalid_next;

    logic                       wsel;
    logic                       conn;
    logic                       oc_seen;
    logic [31:0]                status;

    assign wsel    = reg_req_i.wr && addr_hit(reg_req_i.addr);
    // connection only counts while the port has power
    assign conn    = port_in_i.connected && port_in_i.powered;
    assign oc_seen = port_in_i.overcurrent && port_in_i.oc_per_port;

    always_comb begin
        status                                       = 32'h0000_0000;
        status[RHPS_B_CONN]                          = conn;
        status[RHPS_B_EN]                            = pes_reg;
        status[RHPS_B_SUSP]                          = st_reg[2] | st_reg[3];
        status[RHPS_B_OC]                            = oc_seen;
        status[RHPS_B_RST]                           = st_reg[1];
        status[RHPS_B_POWER]                         = port_in_i.powered;
        status[RHPS_B_CHG_LO+RHPS_CHG_W-1:RHPS_B_CHG_LO] = chg_reg;
    end

    // port sequencing and enable
    always_comb begin
        st_next     = st_reg;
        cnt_next    = cnt_reg;
        pes_next    = pes_reg;
        hc_req_next = hc_req_reg;
        chg_set     = '0;
        case (st_reg)
            RHPS_ST_IDLE: begin
                hc_req_next = 1'b0;
                if (wsel && reg_req_i.wdata[RHPS_B_RST]) begin
                    if (conn) begin
                        st_next  = RHPS_ST_RESET;
                        cnt_next = '0;
                    end else begin
                        chg_set[RHPS_CHG_CONN] = 1'b1;
                    end
                end else if (wsel && reg_req_i.wdata[RHPS_B_SUSP]) begin
                    if (conn) begin
                        st_next = RHPS_ST_SUSPEND;
                    end else begin
                        chg_set[RHPS_CHG_CONN] = 1'b1;
                    end
                end
            end
            RHPS_ST_RESET: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == RHPS_CNT_W'(RESET_CYCLES - 1)) begin
                    st_next               = RHPS_ST_IDLE;
                    chg_set[RHPS_CHG_RST] = 1'b1;
                    pes_next              = 1'b1;
                end
            end
            RHPS_ST_SUSPEND: begin
                if (port_in_i.remote_wake) begin
                    st_next     = RHPS_ST_RESUME;
                    cnt_next    = '0;
                    hc_req_next = 1'b1;
                end else if (wsel && reg_req_i.wdata[RHPS_B_OC]) begin
                    st_next  = RHPS_ST_RESUME;
                    cnt_next = '0;
                end
            end
            RHPS_ST_RESUME: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == RHPS_CNT_W'(RESUME_CYCLES - 1)) begin
                    st_next                = RHPS_ST_IDLE;
                    chg_set[RHPS_CHG_SUSP] = 1'b1;
                    pes_next               = 1'b1;
                    hc_req_next            = 1'b0;
                end
            end
            default: begin
                st_next  = RHPS_ST_IDLE;
                cnt_next = '0;
            end
        endcase

        // controller-wide resume ends any port suspend at once
        if (port_in_i.controller_resume_state && (st_reg[2] || st_reg[3])) begin
            st_next     = RHPS_ST_IDLE;
            hc_req_next = 1'b0;
        end

        // reset command also applies from suspend or resume, not only idle
        if (wsel && reg_req_i.wdata[RHPS_B_RST] && conn && !st_reg[1]) begin
            st_next     = RHPS_ST_RESET;
            cnt_next    = '0;
            hc_req_next = 1'b0;
        end

        if (wsel && reg_req_i.wdata[RHPS_B_EN]) begin
            if (conn) begin
                pes_next = 1'b1;
            end else begin
                chg_set[RHPS_CHG_CONN] = 1'b1;
            end
        end
        if (wsel && reg_req_i.wdata[RHPS_B_CONN]) begin
            pes_next = 1'b0;
        end

        // hub-side faults disable a port that is already enabled; a same-cycle set on a disabled port wins unless disconnected
        if (pes_reg && (port_in_i.overcurrent || !conn || port_in_i.bus_error)) begin
            pes_next              = 1'b0;
            chg_set[RHPS_CHG_EN]  = 1'b1;
        end
        if (!conn) begin
            pes_next    = 1'b0;
            st_next     = RHPS_ST_IDLE;
            cnt_next    = '0;
            hc_req_next = 1'b0;
        end

        if (conn != conn_d_reg) begin
            chg_set[RHPS_CHG_CONN] = 1'b1;
        end
        if (oc_seen && !oc_d_reg) begin
            chg_set[RHPS_CHG_OC] = 1'b1;
        end
    end

    // software clears change flags with a one; a same-cycle event wins
    always_comb begin
        chg_clr  = wsel ? reg_req_i.wdata[RHPS_B_CHG_LO+RHPS_CHG_W-1:RHPS_B_CHG_LO] : '0;
        chg_next = (chg_reg & ~chg_clr) | chg_set;
    end

    // read data is latched so the bus sees a stable word next cycle
    always_comb begin
        rvalid_next = reg_req_i.rd;
        if (reg_req_i.rd && addr_hit(reg_req_i.addr)) begin
            rdata_next = status;
        end else begin
            rdata_next = RHPS_RDATA_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg     <= RHPS_ST_IDLE;
            cnt_reg    <= '0;
            pes_reg    <= 1'b0;
            chg_reg    <= '0;
            conn_d_reg <= 1'b0;
            oc_d_reg   <= 1'b0;
            hc_req_reg <= 1'b0;
            rdata_reg  <= RHPS_RDATA_RST;
            rvalid_reg <= 1'b0;
        end else begin
            st_reg     <= st_next;
            cnt_reg    <= cnt_next;
            pes_reg    <= pes_next;
            chg_reg    <= chg_next;
            conn_d_reg <= conn;
            oc_d_reg   <= oc_seen;
            hc_req_reg <= hc_req_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata_o         = rdata_reg;
    assign reg_rvalid_o        = rvalid_reg;
    assign port_reset_drive_o  = st_reg[1];
    assign port_suspend_o      = st_reg[2];
    assign port_resume_drive_o = st_reg[3];
    assign port_enabled_o      = pes_reg;
    assign hc_resume_req_o     = hc_req_reg;

endmodule // rhps_port_ctrl

// *** rhps_pkg.sv ***
// What this block does
// - write 1 bit 4 starts port reset
// - reset end clears active, sets reset change
// - reset write when disconnected flags connect change
// - bit 3 reads per-port overcurrent, else 0
// - write 1 bit 3 resumes only if suspended
// - bit 2 suspends; clears at resume end
// - suspend write when disconnected flags connect change
// - suspended clears on reset start, controller resume
// - upstream resume propagates to host controller
// - hub-cleared enable also sets enable change
// - enable stays 0 while disconnected
// - reset or resume end sets enable
// - write 1 bit 1 enables, else connect change
// - bit 0 reads connection; write 1 disables
// - power off clears connect, enable, suspend, reset
package rhps_pkg;

    localparam logic [11:0] RHPS_PORT_STATUS_OFS = 12'h054;

    localparam int RHPS_B_CONN   = 0;
    localparam int RHPS_B_EN     = 1;
    localparam int RHPS_B_SUSP   = 2;
    localparam int RHPS_B_OC     = 3;
    localparam int RHPS_B_RST    = 4;
    localparam int RHPS_B_POWER  = 8;
    localparam int RHPS_B_CHG_LO = 16;

    // change flag indices inside the five-bit change field
    localparam int RHPS_CHG_CONN = 0;
    localparam int RHPS_CHG_EN   = 1;
    localparam int RHPS_CHG_SUSP = 2;
    localparam int RHPS_CHG_OC   = 3;
    localparam int RHPS_CHG_RST  = 4;
    localparam int RHPS_CHG_W    = 5;

    localparam logic [31:0] RHPS_RDATA_RST = 32'h0000_0000;

    localparam int RHPS_CLK_MHZ         = 20;
    localparam int RHPS_RESET_TIME_US   = 10000;
    localparam int RHPS_RESUME_TIME_US  = 20000;
    localparam int RHPS_RESET_CYCLES    = RHPS_RESET_TIME_US * RHPS_CLK_MHZ;
    localparam int RHPS_RESUME_CYCLES   = RHPS_RESUME_TIME_US * RHPS_CLK_MHZ;
    localparam int RHPS_CNT_W           = 20;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } rhps_reg_req_t;

    typedef struct packed {
        logic connected;
        logic powered;
        logic overcurrent;
        logic oc_per_port;
        logic bus_error;
        logic remote_wake;
        logic controller_resume_state;
    } rhps_port_in_t;

    typedef enum logic [3:0] {
        RHPS_ST_IDLE    = 4'h1,
        RHPS_ST_RESET   = 4'h2,
        RHPS_ST_SUSPEND = 4'h4,
        RHPS_ST_RESUME  = 4'h8
    } rhps_state_t;

endpackage

// *** rhps_port_ctrl_assertions.sv ***
`timescale 1ns/1ps
module rhps_port_ctrl_chk (
    input wire logic                    core_clk_i,
    input wire logic                    rst_b_i,
    input wire rhps_pkg::rhps_reg_req_t reg_req_i,
    input wire rhps_pkg::rhps_port_in_t port_in_i,
    input wire logic [31:0]             reg_rdata_o,
    input wire logic                    reg_rvalid_o,
    input wire logic                    port_reset_drive_o,
    input wire logic                    port_resume_drive_o,
    input wire logic                    port_suspend_o,
    input wire logic                    port_enabled_o,
    input wire logic                    hc_resume_req_o
);
    import rhps_pkg::*;
    wire w54  = reg_req_i.wr && reg_req_i.addr == RHPS_PORT_STATUS_OFS;
    wire live = port_in_i.connected && port_in_i.powered && !port_in_i.overcurrent;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    rst_start_a: assert property (
        w54 && reg_req_i.wdata[4] && live |=> port_reset_drive_o) else $error("reset not driven");
    rst_refuse_a: assert property (
        w54 && reg_req_i.wdata[4] && !port_in_i.connected |=> !port_reset_drive_o) else $error("reset on empty port");
    rst_done_a: assert property (
        $fell(port_reset_drive_o) && $past(live) && !$past(port_in_i.bus_error)
        |-> port_enabled_o && !port_suspend_o) else $error("reset end wrong");
    en_empty_a: assert property (
        !port_in_i.connected |=> !port_enabled_o) else $error("enabled while empty");
    susp_empty_a: assert property (
        !port_in_i.connected |=> !port_suspend_o) else $error("suspended while empty");
    pwr_off_a: assert property (
        !port_in_i.powered |=> !(port_enabled_o | port_suspend_o | port_reset_drive_o))
        else $error("state kept without power");
    oc_read_a: assert property (
        reg_req_i.rd && reg_req_i.addr == RHPS_PORT_STATUS_OFS && $stable(port_in_i)
        |=> reg_rdata_o[3] == $past(port_in_i.overcurrent && port_in_i.oc_per_port)) else $error("overcurrent bit wrong");
    wake_pass_a: assert property (
        port_suspend_o && !port_resume_drive_o && port_in_i.remote_wake && live && !reg_req_i.wr
        && !port_in_i.controller_resume_state |=> hc_resume_req_o) else $error("wake not passed up");
    res_guard_a: assert property (
        w54 && reg_req_i.wdata[3] && !reg_req_i.wdata[2] && !port_suspend_o && !port_resume_drive_o
        |=> !port_resume_drive_o) else $error("resume while not suspended");
    rd_ans_a: assert property (
        reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
endmodule // rhps_port_ctrl_chk
bind rhps_port_ctrl rhps_port_ctrl_chk chk_u (.core_clk_i, .rst_b_i, .reg_req_i, .port_in_i, .reg_rdata_o,
    .reg_rvalid_o, .port_reset_drive_o, .port_resume_drive_o, .port_suspend_o, .port_enabled_o, .hc_resume_req_o);

// *** rhps_usb_dev.sv ***
`timescale 1ns/1ps
module rhps_usb_dev (
    input  wire logic core_clk_i,
    input  wire logic plug_i,
    input  wire logic wake_i,
    input  wire logic suspended_i,
    input  wire logic resume_seen_i,
    output logic      connected_o = 1'b0,
    output logic      remote_wake_o = 1'b0
);
    // a device may only signal wake while its link sits in suspend
    always @(posedge core_clk_i) begin
        connected_o   <= plug_i;
        remote_wake_o <= wake_i && suspended_i && !resume_seen_i;
    end
endmodule // rhps_usb_dev

// *** rhps_port_ctrl_test.sv ***
`timescale 1ns/1ps
module rhps_port_ctrl_test;
    import rhps_pkg::*;
    localparam int unsigned CYC = 8;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    rhps_reg_req_t req = '0;
    rhps_port_in_t pin;
    logic          pwr = 1'b1, oc = 1'b0, ocpp = 1'b0, berr = 1'b0, crs = 1'b0, plug = 1'b1, wake = 1'b0;
    logic          con, rwk, rvld, rst_drv, res_drv, susp, en, hc_res;
    logic [31:0]   rdata;
    int            failures = 0;
    int            checks = 0;
    always #25 clk = ~clk;
    assign pin = '{con, pwr, oc, ocpp, berr, rwk, crs};
    rhps_usb_dev dev_u (.core_clk_i(clk), .plug_i(plug), .wake_i(wake), .suspended_i(susp),
        .resume_seen_i(res_drv), .connected_o(con), .remote_wake_o(rwk));
    rhps_port_ctrl #(.RESET_CYCLES(CYC), .RESUME_CYCLES(CYC)) dut_u (.core_clk_i(clk), .rst_b_i(rst_b),
        .reg_req_i(req), .port_in_i(pin), .reg_rdata_o(rdata), .reg_rvalid_o(rvld),
        .port_reset_drive_o(rst_drv), .port_resume_drive_o(res_drv), .port_suspend_o(susp),
        .port_enabled_o(en), .hc_resume_req_o(hc_res));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, RHPS_PORT_STATUS_OFS, d};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk) req <= '0;
        #1 cmp(rdata & m, e);
    endtask
    task automatic t_reset;
        wr(32'h001F_0000);
        wr(32'h0000_0000);
        rd(12'h054, 32'h0000_0010, 32'h0);
        wr(32'h0000_0010);
        rd(12'h054, 32'h0010_0010, 32'h0000_0010);
        repeat (CYC + 2) @(posedge clk);
        rd(12'h054, 32'h0010_0016, 32'h0010_0002);
        rd(12'h054, 32'h0010_0000, 32'h0010_0000);
        $display("t_reset done");
    endtask
    task automatic t_disc;
        logic [31:0] cmd [3] = '{32'h10, 32'h04, 32'h02};
        @(posedge clk) plug <= 1'b0;
        repeat (3) @(posedge clk);
        foreach (cmd[i]) begin
            wr(32'h0001_0000);
            wr(cmd[i]);
            rd(12'h054, 32'h0001_0017, 32'h0001_0000);
        end
        rd(12'h058, 32'hFFFF_FFFF, 32'h0);
        @(posedge clk) plug <= 1'b1;
        repeat (3) @(posedge clk);
        $display("t_disc done");
    endtask
    task automatic t_susp;
        wr(32'h001F_0002);
        wr(32'h0000_0004);
        rd(12'h054, 32'h0004_0004, 32'h0000_0004);
        @(posedge clk) wake <= 1'b1;
        repeat (3) @(posedge clk);
        #1 cmp({31'h0, hc_res}, 32'h1);
        @(posedge clk) wake <= 1'b0;
        repeat (CYC + 2) @(posedge clk);
        rd(12'h054, 32'h0004_0006, 32'h0004_0002);
        $display("t_susp done");
    endtask
    task automatic t_swres;
        wr(32'h001F_0008);
        #1 cmp({31'h0, res_drv}, 32'h0);
        wr(32'h0000_0004);
        wr(32'h0000_0008);
        #1 cmp({31'h0, res_drv}, 32'h1);
        @(posedge clk) crs <= 1'b1;
        repeat (2) @(posedge clk);
        crs <= 1'b0;
        rd(12'h054, 32'h0004_0004, 32'h0);
        $display("t_swres done");
    endtask
    task automatic t_oc;
        wr(32'h001F_0002);
        wr(32'h0000_0001);
        rd(12'h054, 32'h0000_0003, 32'h0000_0001);
        wr(32'h001F_0002);
        @(posedge clk) oc <= 1'b1;
        repeat (2) @(posedge clk);
        rd(12'h054, 32'h0002_000A, 32'h0002_0000);
        @(posedge clk) ocpp <= 1'b1;
        rd(12'h054, 32'h0000_0008, 32'h0000_0008);
        @(posedge clk) oc <= 1'b0;
        ocpp <= 1'b0;
        $display("t_oc done");
    endtask
    task automatic t_pwr;
        wr(32'h0000_0002);
        @(posedge clk) pwr <= 1'b0;
        repeat (2) @(posedge clk);
        rd(12'h054, 32'h0000_011F, 32'h0);
        @(posedge clk) pwr <= 1'b1;
        $display("t_pwr done");
    endtask
    task automatic give_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_disc;
        t_susp;
        t_swres;
        t_oc;
        t_pwr;
        give_verdict;
    end
    // whole run needs about 120 cycles
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule // rhps_port_ctrl_test
